// >>> rtl/acg_pkg.sv
// Overview of operation
// - with gain access set, high byte writes index, low byte writes data
// - gain registers are write only, never returned on reads
// - index 0x04 gain high, 0x07 gain low nibble, 0x08 gain add
// - gain upper eight bits in high register, lower four in low register
// - bit 5 set by hardware on conversion done, cleared by software
// - bit 4 reads busy; writing 1 starts only when source is 00b
// - bit 3 set on window match while enabled, stays set until software clears
// - bit 2 selects right (0) or left (1) justified result
// - bits 1:0 select start: busy write, timer 1, pin edge, timer 2
// - control register at 0xe8 page 0x00, bit addressable, resets 0
package acg_pkg;
    localparam logic [7:0] CTRL_ADDR     = 8'he8;
    localparam logic [7:0] CTRL_PAGE     = 8'h00;
    localparam logic [7:0] CONFIG_ADDR   = 8'hbc;
    localparam logic [7:0] RES_LOW_ADDR  = 8'hbd;
    localparam logic [7:0] RES_HIGH_ADDR = 8'hbe;
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [7:0] CONFIG_RESET  = 8'h00;
    localparam int unsigned EN_BIT     = 7;
    localparam int unsigned BURST_BIT  = 6;
    localparam int unsigned DONE_BIT   = 5;
    localparam int unsigned BUSY_BIT   = 4;
    localparam int unsigned WIN_BIT    = 3;
    localparam int unsigned LJ_BIT     = 2;
    localparam int unsigned GAIN_EN_BIT = 0;
    localparam logic [1:0] SRC_SOFT   = 2'h0;
    localparam logic [1:0] SRC_TMR1   = 2'h1;
    localparam logic [1:0] SRC_PIN    = 2'h2;
    localparam logic [1:0] SRC_TMR2   = 2'h3;
    localparam logic [7:0] GIDX_HIGH  = 8'h04;
    localparam logic [7:0] GIDX_LOW   = 8'h07;
    localparam logic [7:0] GIDX_ADD   = 8'h08;
    localparam logic [11:0] GAIN_RESET = 12'h000;
    localparam int unsigned CONV_CYCLES = 16;
endpackage : acg_pkg

// >>> rtl/acg_gain_if.sv
`timescale 1ns/1ps
`default_nettype none
// carries indirect gain writes from the control block to the gain store
interface acg_gain_if;
    logic       wr;
    logic [7:0] idx;
    logic [7:0] data;
    logic [11:0] gain;
    logic       gain_add;
    modport ctrl  (output wr, output idx, output data,
                   input gain, input gain_add);
    modport store (input wr, input idx, input data,
                   output gain, output gain_add);
endinterface : acg_gain_if
`default_nettype wire

// >>> rtl/acg_gain_store.sv
`timescale 1ns/1ps
`default_nettype none
module acg_gain_store
    import acg_pkg::*;
(
    input  wire logic  clock_i,
    input  wire logic  sys_rst_i,
    acg_gain_if.store  gif
);
    logic [7:0] gain_high_reg;
    logic [3:0] gain_low_reg;
    logic       gain_add_bit;
    logic [7:0] next_gain_high;
    logic [3:0] next_gain_low;
    logic       next_gain_add;

    // index decode; unknown indices are dropped silently
    always_comb begin
        next_gain_high = gain_high_reg;
        next_gain_low  = gain_low_reg;
        next_gain_add  = gain_add_bit;
        if (gif.wr) begin
            unique case (gif.idx)
                GIDX_HIGH: next_gain_high = gif.data;
                GIDX_LOW:  next_gain_low = gif.data[7:4];
                GIDX_ADD:  next_gain_add = gif.data[0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            gain_high_reg <= GAIN_RESET[11:4];
            gain_low_reg  <= GAIN_RESET[3:0];
            gain_add_bit  <= 1'b0;
        end else begin
            gain_high_reg <= next_gain_high;
            gain_low_reg  <= next_gain_low;
            gain_add_bit  <= next_gain_add;
        end
    end

    assign gif.gain     = {gain_high_reg, gain_low_reg};
    assign gif.gain_add = gain_add_bit;
endmodule : acg_gain_store
`default_nettype wire

// >>> rtl/acg_control.sv
`timescale 1ns/1ps
`default_nettype none
module acg_control
    import acg_pkg::*;
#(
    parameter int unsigned CONV_LEN = CONV_CYCLES
) (
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic [7:0]  sfr_page_i,
    input  wire logic        sfr_wr_i,
    input  wire logic        sfr_rd_i,
    input  wire logic [7:0]  sfr_wdata_i,
    input  wire logic        sfr_bit_wr_i,
    input  wire logic [2:0]  sfr_bit_sel_i,
    input  wire logic        sfr_bit_val_i,
    output logic      [7:0]  sfr_rdata_o,
    input  wire logic        timer1_ovf_i,
    input  wire logic        timer2_ovf_i,
    input  wire logic        external_convert_start_i,
    input  wire logic [11:0] sample_i,
    input  wire logic        window_match_i,
    output logic             converter_enable_o,
    output logic             burst_mode_enable_o,
    output logic             conversion_busy_o,
    output logic             conv_start_o,
    output logic      [11:0] gain_o,
    output logic             gain_add_bit_o
);
    localparam int unsigned CW = $clog2(CONV_LEN + 1);
    localparam logic [CW-1:0] CONV_LAST = CW'(CONV_LEN - 1);

    acg_gain_if gif ();

    logic [7:0]    converter_control_reg;
    logic [7:0]    converter_config_reg;
    logic [7:0]    result_low_byte;
    logic [7:0]    result_high_byte;
    logic [CW-1:0] conv_cnt;
    logic [7:0]    rdata;
    logic          cnv_meta;
    logic          cnv_sync;
    logic          cnv_prev;
    logic          conv_start;
    logic          gain_wr;
    logic [7:0]    gain_idx;
    logic [7:0]    gain_data;
    logic [11:0]   gain_q;
    logic          gain_add_q;

    logic [7:0]    next_control;
    logic [7:0]    next_config;
    logic [7:0]    next_res_low;
    logic [7:0]    next_res_high;
    logic [CW-1:0] next_conv_cnt;
    logic [7:0]    next_rdata;
    logic          next_gain_wr;
    logic [7:0]    next_gain_idx;
    logic [7:0]    next_gain_data;
    logic          next_conv_start;

    logic          ctrl_sel;
    logic          cfg_sel;
    logic          low_sel;
    logic          high_sel;
    logic          trig;
    logic          hw_trig;
    logic          soft_start;
    logic          finish;
    logic [7:0]    wr_image;
    logic          ctrl_wr;
    logic [15:0]   justified;

    // page 0x00 decode; the other registers are visible on any page
    always_comb begin
        ctrl_sel = (sfr_addr_i == CTRL_ADDR) && (sfr_page_i == CTRL_PAGE);
        cfg_sel  = (sfr_addr_i == CONFIG_ADDR);
        low_sel  = (sfr_addr_i == RES_LOW_ADDR);
        high_sel = (sfr_addr_i == RES_HIGH_ADDR);
    end

    // bit writes merge into the current control image
    always_comb begin
        wr_image = converter_control_reg;
        ctrl_wr  = 1'b0;
        if (ctrl_sel && sfr_wr_i) begin
            wr_image = sfr_wdata_i;
            ctrl_wr  = 1'b1;
        end else if (ctrl_sel && sfr_bit_wr_i) begin
            wr_image[sfr_bit_sel_i] = sfr_bit_val_i;
            ctrl_wr  = 1'b1;
        end
    end

    // hardware start sources; the pin edge is taken after a two-stage sync
    always_comb begin
        hw_trig = 1'b0;
        unique case (converter_control_reg[1:0])
            SRC_SOFT: hw_trig = 1'b0;
            SRC_TMR1: hw_trig = timer1_ovf_i;
            SRC_PIN:  hw_trig = cnv_sync && !cnv_prev;
            SRC_TMR2: hw_trig = timer2_ovf_i;
        endcase
    end

    // a busy write is judged by the image it writes, so one write may
    // enable the converter, pick source 00b and start it together
    always_comb begin
        soft_start = ctrl_wr && wr_image[BUSY_BIT]
                     && (wr_image[1:0] == SRC_SOFT);
    end

    // wr_image equals the register when nothing is written, so a write
    // that disables the converter also drops a same-cycle trigger
    always_comb begin
        trig   = (hw_trig || soft_start) && wr_image[EN_BIT]
                 && !converter_control_reg[BUSY_BIT];
        finish = converter_control_reg[BUSY_BIT] && (conv_cnt == CONV_LAST);
    end

    // result placement in the high/low pair; left justify leaves the
    // low nibble of the low byte zero
    always_comb begin
        if (converter_control_reg[LJ_BIT]) begin
            justified = {sample_i, 4'h0};
        end else begin
            justified = {4'h0, sample_i};
        end
    end

    // control, config and result next values
    always_comb begin
        next_control  = converter_control_reg;
        next_config   = converter_config_reg;
        next_res_low  = result_low_byte;
        next_res_high = result_high_byte;
        next_conv_cnt = conv_cnt;
        next_conv_start = 1'b0;
        if (ctrl_wr) begin
            next_control[EN_BIT]    = wr_image[EN_BIT];
            next_control[BURST_BIT] = wr_image[BURST_BIT];
            next_control[DONE_BIT]  = wr_image[DONE_BIT];
            next_control[WIN_BIT]   = wr_image[WIN_BIT];
            next_control[LJ_BIT]    = wr_image[LJ_BIT];
            next_control[1:0]       = wr_image[1:0];
        end
        if (cfg_sel && sfr_wr_i) begin
            next_config = sfr_wdata_i;
        end
        // result bytes take software writes only while gain access is clear
        if (!converter_config_reg[GAIN_EN_BIT]) begin
            if (high_sel && sfr_wr_i) begin
                next_res_high = sfr_wdata_i;
            end
            if (low_sel && sfr_wr_i) begin
                next_res_low = sfr_wdata_i;
            end
        end
        if (trig) begin
            next_control[BUSY_BIT] = 1'b1;
            next_conv_cnt   = '0;
            next_conv_start = 1'b1;
        end else if (finish) begin
            next_control[BUSY_BIT] = 1'b0;
            next_control[DONE_BIT] = 1'b1;
            next_res_high = justified[15:8];
            next_res_low  = justified[7:0];
        end else if (converter_control_reg[BUSY_BIT]) begin
            next_conv_cnt = conv_cnt + CW'(1);
        end
        // hardware set wins over a software clear in the same cycle
        if (window_match_i && converter_control_reg[EN_BIT]) begin
            next_control[WIN_BIT] = 1'b1;
        end
        // disabling aborts any conversion in flight
        if (!next_control[EN_BIT]) begin
            next_control[BUSY_BIT] = 1'b0;
        end
    end

    // index and data ports reroute while gain access is set; the index
    // is kept, so several data writes may follow one index write
    always_comb begin
        next_gain_wr   = 1'b0;
        next_gain_idx  = gain_idx;
        next_gain_data = gain_data;
        if (converter_config_reg[GAIN_EN_BIT]) begin
            if (high_sel && sfr_wr_i) begin
                next_gain_idx = sfr_wdata_i;
            end
            if (low_sel && sfr_wr_i) begin
                next_gain_data = sfr_wdata_i;
                next_gain_wr   = 1'b1;
            end
        end
    end

    // gain port registers; the write pulse reaches the store one cycle
    // after the bus write, which the store absorbs without a stall
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            gain_wr   <= 1'b0;
            gain_idx  <= 8'h00;
            gain_data <= 8'h00;
        end else begin
            gain_wr   <= next_gain_wr;
            gain_idx  <= next_gain_idx;
            gain_data <= next_gain_data;
        end
    end

    // read mux; gain registers have no read path at all, so a read
    // while gain access is set still shows the result bytes
    always_comb begin
        next_rdata = 8'h00;
        if (sfr_rd_i) begin
            if (ctrl_sel) begin
                next_rdata = converter_control_reg;
            end else if (cfg_sel) begin
                next_rdata = converter_config_reg;
            end else if (low_sel) begin
                next_rdata = result_low_byte;
            end else if (high_sel) begin
                next_rdata = result_high_byte;
            end
        end
    end

    // read data register; zero outside a read so the bus may or-merge it
    // with other peripherals
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    // pin synchroniser: first stage feeds only the second; the third
    // flop only keeps the old level for the rising edge detect
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnv_meta <= 1'b0;
            cnv_sync <= 1'b0;
            cnv_prev <= 1'b0;
        end else begin
            cnv_meta <= external_convert_start_i;
            cnv_sync <= cnv_meta;
            cnv_prev <= cnv_sync;
        end
    end

    // register the next values
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            converter_control_reg <= CTRL_RESET;
            converter_config_reg  <= CONFIG_RESET;
            result_low_byte       <= 8'h00;
            result_high_byte      <= 8'h00;
            conv_cnt              <= '0;
            conv_start            <= 1'b0;
        end else begin
            converter_control_reg <= next_control;
            converter_config_reg  <= next_config;
            result_low_byte       <= next_res_low;
            result_high_byte      <= next_res_high;
            conv_cnt              <= next_conv_cnt;
            conv_start            <= next_conv_start;
        end
    end

    // bus side of the gain port
    assign gif.wr   = gain_wr;
    assign gif.idx  = gain_idx;
    assign gif.data = gain_data;
    assign gain_q     = gif.gain;
    assign gain_add_q = gif.gain_add;

    // the store keeps its own index decode; this side only sees the port
    acg_gain_store u_store (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .gif       (gif)
    );

    // gain outputs retimed so every output leaves a flip-flop
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            gain_o         <= GAIN_RESET;
            gain_add_bit_o <= 1'b0;
        end else begin
            gain_o         <= gain_q;
            gain_add_bit_o <= gain_add_q;
        end
    end

    // every output below is a register or a register bit
    assign sfr_rdata_o         = rdata;
    assign converter_enable_o  = converter_control_reg[EN_BIT];
    assign burst_mode_enable_o = converter_control_reg[BURST_BIT];
    assign conversion_busy_o   = converter_control_reg[BUSY_BIT];
    assign conv_start_o        = conv_start;
endmodule : acg_control
`default_nettype wire

// >>> tb/acg_control_chk.sv
`timescale 1ns/1ps
`default_nettype none
module acg_control_chk
    import acg_pkg::*;
#(
    parameter int unsigned CONV_LEN = 16
) (
    input wire logic        clock_i,
    input wire logic        sys_rst_i,
    input wire logic [7:0]  sfr_addr_i,
    input wire logic        sfr_wr_i,
    input wire logic        sfr_rd_i,
    input wire logic        sfr_bit_wr_i,
    input wire logic [7:0]  sfr_rdata_o,
    input wire logic        converter_enable_o,
    input wire logic        burst_mode_enable_o,
    input wire logic        conversion_busy_o,
    input wire logic        conv_start_o,
    input wire logic [11:0] gain_o,
    input wire logic        gain_add_bit_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    logic [15:0] cnt, next_cnt;
    logic [3:0]  hist, next_hist;
    // busy cycles so far, and data port writes of the last four edges;
    // the gain store lags the bus by a few flops, hence a window
    always_comb begin
        next_cnt  = conversion_busy_o ? cnt + 16'h0001 : 16'h0000;
        next_hist = {hist[2:0], sfr_wr_i && sfr_addr_i == RES_LOW_ADDR};
    end
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt  <= 16'h0000;
            hist <= 4'h0;
        end else begin
            cnt  <= next_cnt;
            hist <= next_hist;
        end
    end
    // a byte or bit write to any address landed one or two edges ago
    sequence s_ctl_wr;
        $past(sfr_wr_i | sfr_bit_wr_i) ||
        $past(sfr_wr_i | sfr_bit_wr_i, 2);
    endsequence
    a_start_busy: assert property (
        $rose(conversion_busy_o) |-> conv_start_o)
        else $error("busy rose without start");
    a_start_enab: assert property (
        conv_start_o |-> converter_enable_o && conversion_busy_o)
        else $error("start while off or idle");
    a_start_once: assert property (
        conv_start_o |=> !conv_start_o)
        else $error("start pulse too long");
    a_busy_length: assert property (
        $fell(conversion_busy_o) && converter_enable_o |-> cnt == CONV_LEN)
        else $error("conversion length wrong");
    a_read_idle: assert property (
        !$past(sfr_rd_i) |-> sfr_rdata_o == 8'h00)
        else $error("read data without read");
    a_gain_cause: assert property (
        $changed(gain_o) |-> |hist)
        else $error("gain moved without write");
    a_add_cause: assert property (
        $changed(gain_add_bit_o) |-> |hist)
        else $error("gain add moved without write");
    a_enable_cause: assert property (
        $changed(converter_enable_o) |-> s_ctl_wr)
        else $error("enable moved without write");
    a_burst_cause: assert property (
        $changed(burst_mode_enable_o) |-> s_ctl_wr)
        else $error("burst moved without write");
endmodule : acg_control_chk
bind acg_control acg_control_chk #(.CONV_LEN(CONV_LEN)) i_chk (.*);
`default_nettype wire

// >>> tb/acg_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module acg_control_tb
    import acg_pkg::*;
;
    localparam int unsigned CL = 4;
    logic        clock_i, sys_rst_i, sfr_wr_i, sfr_rd_i, sfr_bit_wr_i;
    logic        sfr_bit_val_i, timer1_ovf_i, timer2_ovf_i, rd_d;
    logic        external_convert_start_i, window_match_i;
    logic        converter_enable_o, burst_mode_enable_o, gain_add_bit_o;
    logic        conversion_busy_o, conv_start_o;
    logic [2:0]  sfr_bit_sel_i;
    logic [7:0]  sfr_addr_i, sfr_page_i, sfr_wdata_i, sfr_rdata_o;
    logic [11:0] sample_i, gain_o, s;
    logic [31:0] seed, r;
    logic [7:0]  exp_q[$];
    int          fails, comparisons, cycles, starts;

    acg_control #(.CONV_LEN(CL)) i_acg_control (.*);

    task automatic complete_run;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [11:0] g, input logic [11:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // wait n edges, then sit just after the last one
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : tick
    // op 0 read (expected byte queued), 1 byte write, 2 bit write with
    // d[2:0] the bit and d[3] its value; an idle cycle keeps strobes apart
    task automatic bus(input int op, input logic [7:0] a,
                       input logic [7:0] d);
        if (op == 0) exp_q.push_back(d);
        sfr_rd_i      = (op == 0);
        sfr_wr_i      = (op == 1);
        sfr_bit_wr_i  = (op == 2);
        sfr_addr_i    = a;
        sfr_wdata_i   = d;
        sfr_bit_sel_i = d[2:0];
        sfr_bit_val_i = d[3];
        tick(1);
        {sfr_rd_i, sfr_wr_i, sfr_bit_wr_i} = 3'h0;
        tick(1);
    endtask : bus
    // pulse one start source: 1 timer 1, 2 pin edge, 3 timer 2
    task automatic trig(input int t);
        timer1_ovf_i = (t == 1);
        external_convert_start_i = (t == 2);
        timer2_ovf_i = (t == 3);
        tick(1);
        {timer1_ovf_i, timer2_ovf_i} = 2'h0;
        tick(3);
        external_convert_start_i = 1'b0;
        tick(3);
    endtask : trig

    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    // cut a hang short, far beyond the few hundred cycles of the run
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            complete_run();
        end
    end
    // read data stands the cycle after the strobe: compare mid-cycle
    always @(posedge clock_i) rd_d <= sfr_rd_i;
    always @(negedge clock_i) begin
        if (rd_d === 1'b1) begin
            if (exp_q.size() == 0) chk(12'hfff, 12'h000);
            else chk({4'h0, sfr_rdata_o}, {4'h0, exp_q.pop_front()});
        end
    end
    // start pulses, counted mid-cycle while they stand
    always @(negedge clock_i) begin
        if (conv_start_o === 1'b1) starts++;
    end

    initial begin
        seed = 32'h6d31d3d2;
        {sfr_wr_i, sfr_rd_i, sfr_bit_wr_i, sfr_bit_val_i} = 4'h0;
        {timer1_ovf_i, timer2_ovf_i, external_convert_start_i} = 3'h0;
        {window_match_i, sfr_bit_sel_i, sample_i} = 16'h0000;
        {sfr_addr_i, sfr_page_i, sfr_wdata_i} = 24'h000000;
        sys_rst_i = 1'b1;
        tick(16);
        sys_rst_i = 1'b0;
        // reset value, unmapped read, control write on a foreign page
        bus(0, CTRL_ADDR, CTRL_RESET);
        bus(0, 8'h55, 8'h00);
        sfr_page_i = 8'h0f;
        bus(1, CTRL_ADDR, 8'h80);
        sfr_page_i = CTRL_PAGE;
        bus(0, CTRL_ADDR, CTRL_RESET);
        // software start by byte then by bit, right then left justified
        for (int k = 0; k < 2; k++) begin
            r = $random(seed);
            s = r[11:0];
            sample_i = s;
            bus(1, CTRL_ADDR, k ? 8'h84 : 8'h90);
            if (k) bus(2, CTRL_ADDR, 8'h0c);
            else bus(1, CTRL_ADDR, 8'h80);
            chk(conversion_busy_o, 1'b1);
            tick(CL + 2);
            chk(conversion_busy_o, 1'b0);
            bus(0, CTRL_ADDR, k ? 8'ha4 : 8'ha0);
            bus(0, RES_HIGH_ADDR, k ? s[11:4] : {4'h0, s[11:8]});
            bus(0, RES_LOW_ADDR, k ? {s[3:0], 4'h0} : s[7:0]);
        end
        // each hardware source ignores busy writes and foreign triggers
        for (int m = 1; m < 4; m++) begin
            r = $random(seed);
            s = r[11:0];
            sample_i = s;
            bus(1, CTRL_ADDR, 8'h90 | m[7:0]);
            for (int t = 1; t < 4; t++)
                if (t != m) trig(t);
            bus(0, CTRL_ADDR, 8'h80 | m[7:0]);
            trig(m);
            tick(CL + 2);
            bus(0, CTRL_ADDR, 8'ha0 | m[7:0]);
            bus(0, RES_LOW_ADDR, s[7:0]);
        end
        // window flag holds until software clears it
        window_match_i = 1'b1;
        tick(1);
        window_match_i = 1'b0;
        tick(3);
        bus(0, CTRL_ADDR, 8'hab);
        bus(1, CTRL_ADDR, 8'h80);
        bus(0, CTRL_ADDR, 8'h80);
        // burst on, then disable; a start while off is dropped
        bus(2, CTRL_ADDR, 8'h0e);
        chk(burst_mode_enable_o, 1'b1);
        bus(2, CTRL_ADDR, 8'h07);
        bus(2, CTRL_ADDR, 8'h0c);
        chk(converter_enable_o, 1'b0);
        bus(0, CTRL_ADDR, 8'h40);
        // gain access set, index then data, access cleared before any
        // conversion; an unknown index is dropped
        r = $random(seed);
        bus(1, CONFIG_ADDR, 8'h01);
        bus(1, RES_HIGH_ADDR, GIDX_HIGH);
        bus(1, RES_LOW_ADDR, r[15:8]);
        bus(1, RES_HIGH_ADDR, GIDX_LOW);
        bus(1, RES_LOW_ADDR, r[7:0]);
        bus(1, RES_HIGH_ADDR, GIDX_ADD);
        bus(1, RES_LOW_ADDR, 8'h01);
        bus(1, RES_HIGH_ADDR, 8'h05);
        bus(1, RES_LOW_ADDR, 8'hff);
        bus(1, CONFIG_ADDR, 8'h00);
        tick(4);
        chk(gain_o, {r[15:8], r[7:4]});
        chk(gain_add_bit_o, 1'b1);
        bus(0, RES_HIGH_ADDR, {4'h0, s[11:8]});
        bus(0, RES_LOW_ADDR, s[7:0]);
        // a second reset in mid-run
        sys_rst_i = 1'b1;
        tick(2);
        sys_rst_i = 1'b0;
        chk(gain_o, GAIN_RESET);
        bus(0, CTRL_ADDR, CTRL_RESET);
        tick(2);
        chk(exp_q.size() == 0, 1'b1);
        chk(starts[11:0], 12'h005);
        complete_run();
    end
endmodule : acg_control_tb
`default_nettype wire
